// ---- vbr_vbus_detect_regulator_ctrl.sv ----
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// R1 - bit 6 reads live bus supply level
// R2 - enabled interrupt when level equals polarity
// R3 - interrupt level-only, no pending flag
// R4 - bit 5 selects interrupt active level
// R5 - reset request when enabled and matching
// R6 - bit 7 read/write regulator disable
// R7 - bit 4 read/write low-power mode select
// R8 - low four bits read zero
// R9 - bus supply input synchronised twice
// R10 - writable control bits reset to zero
module vbr_vbus_detect_regulator_ctrl (
  input  wire logic        mclk,                    // 40 MHz system clock
  input  wire logic        rst,                     // sync reset, active high
  input  wire logic        psel,                    // apb select
  input  wire logic        penable,                 // apb enable
  input  wire logic        pwrite,                  // apb direction
  input  wire logic [11:0] paddr,                   // apb byte address
  input  wire logic [31:0] pwdata,                  // apb write data
  input  wire logic [3:0]  pstrb,                   // apb byte strobes
  output logic      [31:0] prdata,                  // apb read data
  output logic             pready,                  // apb ready
  output logic             pslverr,                 // apb error
  input  wire logic        bus_supply_in,           // async bus supply pin
  output logic             regulator_off,           // regulator disabled
  output logic             regulator_low_power_sel, // regulator suspend mode
  output logic             bus_supply_irq,          // level match interrupt
  output logic             bus_reset_req,           // system reset request
  output logic             irq                      // masked event interrupt
);
  import vbr_pkg::*;

  vbr_reg_ctrl_type ctrl_r;
  logic             pol_r;
  logic             match_irq_en_r;
  logic             reset_src_en_r;
  logic [1:0]       stat_r;
  logic [1:0]       mask_r;
  logic             level_s;
  logic             level_d_r;
  logic             match;
  logic             acc;
  logic             wr_acc;
  logic [1:0]       ev_set;
  logic [31:0]      rd_nxt;
  logic             err_nxt;
  vbr_out_type      out_r;

  // address match helper, used by read and write paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // pin is asynchronous to mclk
  vbr_sync u_sync ( // R9
    .mclk  (mclk),
    .rst   (rst),
    .d_in  (bus_supply_in),
    .q_out (level_s)
  );

  // one-cycle access phase, no wait states
  assign acc    = psel && penable && pready;
  assign wr_acc = acc && pwrite && pstrb[0];
  assign match  = (level_s == pol_r); // R2 R4

  // edge events for the sticky status bits
  assign ev_set[VBR_EV_RISE] = level_s && !level_d_r;
  assign ev_set[VBR_EV_FALL] = !level_s && level_d_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      level_d_r <= 1'b0;
    end else begin
      level_d_r <= level_s;
    end
  end

  // pready: ready in the access cycle only
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // control bits; reserved low nibble is not stored
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r.regulator_off           <= VBR_CTRL_RST[VBR_OFF_BIT];    // R10
      ctrl_r.regulator_low_power_sel <= VBR_CTRL_RST[VBR_LOWPWR_BIT]; // R10
      pol_r                          <= VBR_CTRL_RST[VBR_POL_BIT];    // R10
    end else if (wr_acc && hit(paddr, VBR_CTRL_OFS)) begin
      ctrl_r.regulator_off           <= pwdata[VBR_OFF_BIT];    // R6
      ctrl_r.regulator_low_power_sel <= pwdata[VBR_LOWPWR_BIT]; // R7
      pol_r                          <= pwdata[VBR_POL_BIT];    // R4
    end
  end

  // enables: bit 0 level interrupt, bit 1 bus as reset source
  always_ff @(posedge mclk) begin
    if (rst) begin
      match_irq_en_r <= 1'b0;
      reset_src_en_r <= 1'b0;
    end else if (wr_acc && hit(paddr, VBR_SRC_OFS)) begin
      match_irq_en_r <= pwdata[0];
      reset_src_en_r <= pwdata[1];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mask_r <= VBR_MASK_RST;
    end else if (wr_acc && hit(paddr, VBR_IRQ_MASK_OFS)) begin
      mask_r <= pwdata[1:0];
    end
  end

  // sticky events, write one to clear; a new event wins over the clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      stat_r <= VBR_STAT_RST;
    end else if (wr_acc && hit(paddr, VBR_IRQ_STAT_OFS)) begin
      stat_r <= (stat_r & ~pwdata[1:0]) | ev_set;
    end else begin
      stat_r <= stat_r | ev_set;
    end
  end

  // read mux and unmapped-address error
  always_comb begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (hit(paddr, VBR_CTRL_OFS)) begin
      rd_nxt[VBR_OFF_BIT]    = ctrl_r.regulator_off;           // R6
      rd_nxt[VBR_LEVEL_BIT]  = level_s;                        // R1
      rd_nxt[VBR_POL_BIT]    = pol_r;                          // R4
      rd_nxt[VBR_LOWPWR_BIT] = ctrl_r.regulator_low_power_sel; // R7
      rd_nxt[3:0]            = 4'h0;                           // R8
    end else if (hit(paddr, VBR_IRQ_STAT_OFS)) begin
      rd_nxt[1:0] = stat_r;
    end else if (hit(paddr, VBR_IRQ_MASK_OFS)) begin
      rd_nxt[1:0] = mask_r;
    end else if (hit(paddr, VBR_SRC_OFS)) begin
      rd_nxt[1:0] = {reset_src_en_r, match_irq_en_r};
    end else begin
      err_nxt = 1'b1;
    end
  end

  // read data registered on the setup cycle so it stands in access phase
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr <= err_nxt;
    end else begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // level outputs follow the match with no latch; irq follows the masked sticky status
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_r <= '0;
    end else begin
      out_r.match_irq <= match_irq_en_r && match;  // R2 R3
      out_r.reset_req <= reset_src_en_r && match;  // R5
      out_r.event_irq <= |(stat_r & mask_r);
    end
  end

  assign regulator_off           = ctrl_r.regulator_off;
  assign regulator_low_power_sel = ctrl_r.regulator_low_power_sel;
  assign bus_supply_irq          = out_r.match_irq;
  assign bus_reset_req           = out_r.reset_req;
  assign irq                     = out_r.event_irq;
endmodule // vbr_vbus_detect_regulator_ctrl

// ---- vbr_pkg.sv ----
package vbr_pkg;

  // register map (byte addresses, one aligned word each)
  localparam logic [11:0] VBR_CTRL_OFS     = 12'h000;
  localparam logic [11:0] VBR_IRQ_STAT_OFS = 12'h004;
  localparam logic [11:0] VBR_IRQ_MASK_OFS = 12'h008;
  localparam logic [11:0] VBR_SRC_OFS      = 12'h00c;

  // control register field positions
  localparam int VBR_OFF_BIT    = 7;
  localparam int VBR_LEVEL_BIT  = 6;
  localparam int VBR_POL_BIT    = 5;
  localparam int VBR_LOWPWR_BIT = 4;

  // reset values
  localparam logic [7:0] VBR_CTRL_RST = 8'h00;
  localparam logic [1:0] VBR_STAT_RST = 2'h0;
  localparam logic [1:0] VBR_MASK_RST = 2'h0;

  // event status bits: 0 = supply arrived, 1 = supply lost
  localparam int VBR_EV_RISE = 0;
  localparam int VBR_EV_FALL = 1;

  localparam int VBR_SYNC_STAGES = 2;

  typedef struct packed {
    logic regulator_off;
    logic regulator_low_power_sel;
  } vbr_reg_ctrl_type;

  typedef struct packed {
    logic match_irq;
    logic reset_req;
    logic event_irq;
  } vbr_out_type;

endpackage

// ---- vbr_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser; first stage feeds only the second
module vbr_sync (
  input  wire logic mclk,   // system clock
  input  wire logic rst,    // sync reset
  input  wire logic d_in,   // async input
  output logic      q_out   // synchronised level
);
  import vbr_pkg::*;

  logic [VBR_SYNC_STAGES-1:0] stage_r;

  // shift chain
  always_ff @(posedge mclk) begin
    if (rst) begin
      stage_r <= '0;
    end else begin
      stage_r <= {stage_r[VBR_SYNC_STAGES-2:0], d_in};
    end
  end

  assign q_out = stage_r[VBR_SYNC_STAGES-1];
endmodule // vbr_sync

// ---- vbr_host_model.sv ----
`timescale 1ns/1ps
// host side of the supply line; skewed so the pin is async
module vbr_host_model (
  input  wire logic attach, // host plugged in
  output wire logic vbus    // supply pin level
);
  assign #7 vbus = attach;
endmodule // vbr_host_model

// ---- vbr_checker.sv ----
`timescale 1ns/1ps
module vbr_checker (
  input wire logic        mclk,                    // clock
  input wire logic        rst,                     // reset
  input wire logic        psel,                    // select
  input wire logic        penable,                 // enable
  input wire logic        pwrite,                  // write
  input wire logic [11:0] paddr,                   // address
  input wire logic [31:0] pwdata,                  // wdata
  input wire logic [3:0]  pstrb,                   // strobes
  input wire logic [31:0] prdata,                  // rdata
  input wire logic        pready,                  // ready
  input wire logic        bus_supply_in,           // pin
  input wire logic        regulator_off,           // off
  input wire logic        regulator_low_power_sel, // low power
  input wire logic        bus_supply_irq,          // level irq
  input wire logic        bus_reset_req            // reset req
);
  logic [2:0] up_r;
  logic [2:0] qw_r;
  logic       wr;
  logic       rd0;
  assign wr  = psel && penable && pready && pwrite;
  assign rd0 = pready && !pwrite && paddr == 12'h000;
  // edges since reset, so synchroniser lag is not flagged
  always_ff @(posedge mclk) begin
    if (rst) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  // edges since last write
  always_ff @(posedge mclk) begin
    if (rst || wr) qw_r <= 3'h0;
    else if (qw_r != 3'h7) qw_r <= qw_r + 3'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence ctrl_wr; wr && paddr == 12'h000 && pstrb[0]; endsequence
  sequence calm; $stable(bus_supply_in) [*4]; endsequence
  lvl_bit_a: assert property (calm ##0 (rd0 && up_r == 3'h7) |-> prdata[6] == bus_supply_in)
    else $error("level bit wrong");
  low_zero_a: assert property (rd0 |-> prdata[3:0] == 4'h0)
    else $error("low bits not zero");
  off_wr_a: assert property (ctrl_wr |=> regulator_off == $past(pwdata[7]))
    else $error("off bit not written");
  lp_wr_a: assert property (ctrl_wr |=> regulator_low_power_sel == $past(pwdata[4]))
    else $error("mode bit not written");
  ctrl_hold_a: assert property (!(wr && paddr == 12'h000) |=> $stable({regulator_off, regulator_low_power_sel}))
    else $error("control changed");
  rd_back_a: assert property (rd0 |-> prdata[7] == regulator_off && prdata[4] == regulator_low_power_sel)
    else $error("read back wrong");
  rst_zero_a: assert property ($fell(rst) |-> !regulator_off && !regulator_low_power_sel && !bus_reset_req)
    else $error("not zero after reset");
  irq_steady_a: assert property (calm ##0 (qw_r == 3'h7) |=> $stable({bus_supply_irq, bus_reset_req}))
    else $error("level output moved");
endmodule // vbr_checker
bind vbr_vbus_detect_regulator_ctrl vbr_checker chk_i (.*);

// ---- vbr_vbus_detect_regulator_ctrl_test.sv ----
`timescale 1ns/1ps
module vbr_vbus_detect_regulator_ctrl_test;
  import vbr_pkg::*;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, attach, vbus, r_off, r_lp, virq, vrst, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic [3:0]  pstrb;
  int          n_errors, n_compared, seed, i, n, lvl, st, msk, en;
  vbr_host_model host (.attach(attach), .vbus(vbus));
  vbr_vbus_detect_regulator_ctrl uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_supply_in(vbus), .regulator_off(r_off), .regulator_low_power_sel(r_lp), .bus_supply_irq(virq),
    .bus_reset_req(vrst), .irq(irq));
  // 40 MHz clock
  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  task end_sim;
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
      n_errors++;
    end
  endtask
  // one apb transfer; bounded wait on pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    int k;
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= v; pstrb <= 4'hf;
    @(posedge mclk);
    penable <= 1;
    k = 0;
    // look mid-cycle: the answer then stands unchanged up to the closing edge
    do begin @(negedge mclk); k++; end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin n_errors++; end_sim; end
    rd = prdata; err = pslverr;
    @(posedge mclk);
    psel <= 0; penable <= 0;
  endtask
  initial begin
    seed = 53; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 0; attach = 0;
    n_errors = 0; n_compared = 0; lvl = 0; st = 0;
    repeat (5) @(posedge mclk);
    rst <= 0;
    apb(0, VBR_CTRL_OFS, 0); chk(rd, 0);
    apb(0, 12'h010, 0); chk(err, 1);
    // random pin, control, enables and mask against the model
    for (i = 0; i < 40; i++) begin
      n = $random(seed) & 1;
      if (n != lvl) st |= (n != 0) ? 1 : 2;
      lvl = n; attach <= n[0];
      d = $random(seed) & 32'hf0; en = $random(seed) & 3; msk = $random(seed) & 3;
      apb(1, VBR_CTRL_OFS, d); apb(1, VBR_SRC_OFS, en); apb(1, VBR_IRQ_MASK_OFS, msk);
      repeat (6) @(posedge mclk);
      apb(0, VBR_CTRL_OFS, 0); chk(rd, (d & 32'hb0) | (lvl << 6));
      chk(virq, en[0] && lvl == d[5]);
      chk(vrst, en[1] && lvl == d[5]);
      chk({r_off, r_lp}, {d[7], d[4]});
      apb(0, VBR_IRQ_STAT_OFS, 0); chk(rd, st); chk(irq, (st & msk) != 0);
      apb(1, VBR_IRQ_STAT_OFS, st); st = 0;
    end
    // second reset mid-run
    @(posedge mclk) rst <= 1;
    repeat (3) @(posedge mclk);
    rst <= 0;
    repeat (4) @(posedge mclk);
    apb(0, VBR_CTRL_OFS, 0); chk(rd, lvl << 6);
    end_sim;
  end
endmodule // vbr_vbus_detect_regulator_ctrl_test
